// ---- tb/test_timer_gate_and_ext_irq_inputs.sv ----
/* test_timer_gate_and_ext_irq_inputs: self-checking bench.
   assumes every bus request is answered before the watchdog. */
module test_timer_gate_and_ext_irq_inputs;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    mclk = 1'b0, nrst = 1'b0, clkEn = 1'b1;
    logic                    avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest;
    logic [3:0]              avsAddress = 4'h0, cnt;
    logic [31:0]             avsWriteData = 32'h0, avsReadData;
    logic [1:0]              irqPending;
    tgei_pkg::tgei_pins_type pins;
    logic [31:0]             expQ[$];
    int                      fails = 0, checks = 0;
    always #20 mclk = ~mclk;
    tgei_pins_model u_pins (.mclk(mclk), .pins(pins));
    tgei_timer_gate_irq u_dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
        .pins(pins), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'hF), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .irqPending(irqPending));
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH readData exp %h got %h", e, g);
        end
    endtask : cmp
    task automatic cmpPend(input logic [1:0] e);
        checks++;
        if (irqPending !== e) begin
            fails++;
            $display("MISMATCH irqPending exp %h got %h", e, irqPending);
        end
    endtask : cmpPend
    // request held until waitrequest is seen low, dropped at that edge
    task automatic acc(input logic w, input logic [3:0] a, input int d);
        @(posedge mclk);
        {avsAddress, avsWrite, avsRead, avsWriteData} <= {a, w, !w, d};
        do @(posedge mclk); while (avsWaitRequest !== 1'b0);
        {avsWrite, avsRead} <= 2'b00;
    endtask : acc
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        acc(1'b0, a, 0);
    endtask : rd
    // oldest note against each completed read
    always @(posedge mclk)
        if (avsRead && avsWaitRequest === 1'b0) cmp(expQ.pop_front(), avsReadData);
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h8C4E));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        // reset values, then an unmapped address
        for (int k = 0; k < 4; k++) rd(4'(k * 4), 32'h0);
        rd(4'h2, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 2; i++) begin
            cnt = i ? tgei_pkg::CNTB_OFS : tgei_pkg::CNTA_OFS;
            acc(1'b1, cnt, 32'hFFFE);
            // 55: run, gate, edge trigger, counter mode
            acc(1'b1, tgei_pkg::CTRL_OFS, 32'h55 << i);
            u_pins.setIrq(i, 1'b0);
            u_pins.pulses(i, 2);
            rd(cnt, 32'hFFFE);
            rd(tgei_pkg::STAT_OFS, 32'h1 << i);
            cmpPend(2'(1 << i));
            acc(1'b1, tgei_pkg::STAT_OFS, 32'h1 << i);
            rd(tgei_pkg::STAT_OFS, 32'h0);
            cmpPend(2'h0);
            // 45: same but level trigger, pin still low
            acc(1'b1, tgei_pkg::CTRL_OFS, 32'h45 << i);
            rd(tgei_pkg::STAT_OFS, 32'h1 << i);
            cmpPend(2'(1 << i));
            u_pins.setIrq(i, 1'b1);
            acc(1'b1, tgei_pkg::STAT_OFS, 32'h1 << i);
            rd(tgei_pkg::STAT_OFS, 32'h0);
            cmpPend(2'h0);
            u_pins.pulses(i, 3);
            rd(cnt, 32'h0001);
            $display("channel %0d test done", i);
        end
        clkEn <= 1'b0;
        repeat (3) @(posedge mclk);
        clkEn <= 1'b1;
        stop_test();
    end
endmodule : test_timer_gate_and_ext_irq_inputs

// ---- tb/tgei_checker.sv ----
/* tgei_checker: port assertions for the gate and irq block.
   assumes one mclk domain, bound onto the design top. */
module tgei_checker (
    input wire logic                    mclk,           // clock
    input wire logic                    nrst,           // reset
    input wire logic                    clkEn,          // enable
    input wire tgei_pkg::tgei_pins_type pins,           // pins
    input wire logic [3:0]              avsAddress,     // addr
    input wire logic                    avsRead,        // rd
    input wire logic                    avsWrite,       // wr
    input wire logic [31:0]             avsWriteData,   // wdata
    input wire logic [3:0]              avsByteEnable,  // lanes
    input wire logic [31:0]             avsReadData,    // rdata
    input wire logic                    avsWaitRequest, // stall
    input wire logic [1:0]              irqPending      // flags
);
    logic [1:0][7:0] lowSeen_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // pin low history, deep enough for sync plus flag latency
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) lowSeen_q <= '0;
        else lowSeen_q <= {lowSeen_q[1][6:0], !pins.extIrqIn[1],
                           lowSeen_q[0][6:0], !pins.extIrqIn[0]};
    end
    waitOne_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low two cycles");
    waitCause_a: assert property (!avsWaitRequest |-> $past(avsRead|avsWrite))
        else $error("answer without request");
    pendA_a: assert property ($rose(irqPending[0]) |-> |lowSeen_q[0])
        else $error("pending a set without low pin");
    pendB_a: assert property ($rose(irqPending[1]) |-> |lowSeen_q[1])
        else $error("pending b set without low pin");
    clrA_a: assert property ($fell(irqPending[0]) |-> $past(avsWrite, 2))
        else $error("pending a lost without write");
    clrB_a: assert property ($fell(irqPending[1]) |-> $past(avsWrite, 2))
        else $error("pending b lost without write");
    ctrlRd_a: assert property (!avsWaitRequest && avsRead && avsAddress < 4'h8
        |-> avsReadData[31:8] == 24'h000000) else $error("upper bits set");
    freeze_a: assert property (!clkEn |=> $stable(irqPending))
        else $error("flags moved while frozen");
    cover property (avsRead && !avsWaitRequest);
    cover property ($rose(irqPending[0]));
    cover property ($fell(irqPending[1]));
endmodule : tgei_checker
bind tgei_timer_gate_irq tgei_checker u_chk (.mclk(mclk), .nrst(nrst),
    .clkEn(clkEn), .pins(pins), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .irqPending(irqPending));

// ---- tb/tgei_pins_model.sv ----
/* tgei_pins_model: board logic on the irq and count pins.
   assumes pull-ups keep pins high when idle. */
module tgei_pins_model (
    input wire logic                mclk, // clock
    output tgei_pkg::tgei_pins_type pins  // pins
);
    initial pins = '1;
    // level change, then time for sync and flag logic to settle
    task automatic setIrq(input int i, input logic v);
        pins.extIrqIn[i] <= v;
        repeat (8) @(posedge mclk);
    endtask : setIrq
    // random 2..4 cycle levels, never shorter than the sync needs
    task automatic pulses(input int i, input int n);
        repeat (2 * n) begin
            pins.countIn[i] <= ~pins.countIn[i];
            repeat ($urandom % 3 + 2) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask : pulses
endmodule : tgei_pins_model

// ---- verilog/tgei_pkg.sv ----
/*
 * tgei_pkg: register map, field positions and carrier types for the
 * timer gate and external interrupt input block.
 * Assumes a 32-bit Avalon-MM slave with word-aligned registers.
 */
package tgei_pkg;

    // register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0; // control bits
    localparam logic [3:0] STAT_OFS   = 4'h4; // pending flags, w1c
    localparam logic [3:0] CNTA_OFS   = 4'h8; // count a
    localparam logic [3:0] CNTB_OFS   = 4'hC; // count b

    // control register fields
    localparam int RUN_A_BIT     = 0;
    localparam int RUN_B_BIT     = 1;
    localparam int GATE_A_BIT    = 2;
    localparam int GATE_B_BIT    = 3;
    localparam int TRIG_A_BIT    = 4;
    localparam int TRIG_B_BIT    = 5;
    localparam int CMODE_A_BIT   = 6;
    localparam int CMODE_B_BIT   = 7;
    localparam int CTRL_W        = 8;

    // status register fields
    localparam int PEND_A_BIT    = 0;
    localparam int PEND_B_BIT    = 1;

    localparam int CNT_W         = 16;
    localparam int NCH           = 2;

    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
    localparam logic [31:0]       RD_ZERO  = 32'h00000000;

    // per-channel pin group, index 0 = a, 1 = b
    typedef struct packed {
        logic [NCH-1:0] extIrqIn;   // active-low interrupt / gate pins
        logic [NCH-1:0] countIn;    // external count pins
    } tgei_pins_type;

    // bus access states
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_DONE
    } tgei_bus_type;

endpackage : tgei_pkg

// ---- verilog/tgei_timer_gate_irq.sv ----
/*
 * tgei_timer_gate_irq: two 16-bit timers with external gating and
 * event counting, plus two external interrupt pending flags.
 * Assumes pins are asynchronous to mclk and software reaches the
 * registers over Avalon-MM with waitrequest.
 */
// Local design decisions: register access over Avalon-MM and the placing of the registers.
module tgei_timer_gate_irq (
    input  wire logic                  mclk,         // 25 MHz clock
    input  wire logic                  nrst,         // async reset, low
    input  wire logic                  clkEn,        // freezes state low
    input  wire tgei_pkg::tgei_pins_type pins,       // external pins
    input  wire logic [3:0]            avsAddress,   // byte address
    input  wire logic                  avsRead,      // read request
    input  wire logic                  avsWrite,     // write request
    input  wire logic [31:0]           avsWriteData, // write data
    input  wire logic [3:0]            avsByteEnable,// byte lanes
    output logic [31:0]                avsReadData,  // read data
    output logic                       avsWaitRequest,// stall
    output logic [1:0]                 irqPending    // pending flags
);

    logic [3:0]  syncA_q;         // first stage, read only by syncB_q
    logic [3:0]  syncB_q;         // second stage
    logic [3:0]  prev_q;          // previous synchronised level
    logic [tgei_pkg::CTRL_W-1:0] ctrl_q;
    logic [1:0]  pend_q;
    logic [tgei_pkg::CNT_W-1:0]  cnt_q [tgei_pkg::NCH];
    tgei_pkg::tgei_bus_type busState_q;
    logic        busAcc;
    logic        wrAcc;

    // two-flop synchroniser for all four pins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            syncA_q <= 4'hF;
            syncB_q <= 4'hF;
            prev_q  <= 4'hF;
        end else if (clkEn) begin
            syncA_q <= {pins.countIn, pins.extIrqIn};
            syncB_q <= syncA_q;
            prev_q  <= syncB_q;
        end
    end

    // one wait state: access completes on the second cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busState_q <= tgei_pkg::BUS_IDLE;
        end else if (clkEn) begin
            case (busState_q)
                tgei_pkg::BUS_IDLE: begin
                    if (avsRead || avsWrite) begin
                        busState_q <= tgei_pkg::BUS_DONE;
                    end
                end
                tgei_pkg::BUS_DONE: begin
                    busState_q <= tgei_pkg::BUS_IDLE;
                end
                default: begin
                    busState_q <= tgei_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    assign busAcc = clkEn && (busState_q == tgei_pkg::BUS_IDLE)
                    && (avsRead || avsWrite);
    // writes land at the edge where the master sees waitrequest low
    assign wrAcc  = clkEn && (busState_q == tgei_pkg::BUS_DONE)
                    && avsWrite;

    // waitrequest high except in the completing cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avsWaitRequest <= 1'b1;
        end else if (clkEn) begin
            avsWaitRequest <= !(busAcc);
        end
    end

    // read data registered alongside the wait release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avsReadData <= tgei_pkg::RD_ZERO;
        end else if (busAcc && avsRead) begin
            case (avsAddress)
                tgei_pkg::CTRL_OFS: avsReadData <= {24'h000000, ctrl_q};
                tgei_pkg::STAT_OFS: avsReadData <= {30'h00000000, pend_q};
                tgei_pkg::CNTA_OFS: avsReadData <= {16'h0000, cnt_q[0]};
                tgei_pkg::CNTB_OFS: avsReadData <= {16'h0000, cnt_q[1]};
                default:            avsReadData <= tgei_pkg::RD_ZERO;
            endcase
        end
    end

    // control register, low byte lane only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= tgei_pkg::CTRL_RST;
        end else if (wrAcc && avsByteEnable[0]
                     && avsAddress == tgei_pkg::CTRL_OFS) begin
            ctrl_q <= avsWriteData[tgei_pkg::CTRL_W-1:0];
        end
    end

    // per-channel pending flag and timer
    genvar ch;
    generate
        for (ch = 0; ch < tgei_pkg::NCH; ch++) begin : g_ch
            logic irqLow;
            logic irqFall;
            logic cntFall;
            logic trig;
            logic gate;
            logic run;
            logic cmode;
            logic clr;
            logic tick;

            assign irqLow  = !syncB_q[ch];
            assign irqFall = prev_q[ch] && !syncB_q[ch];
            assign cntFall = prev_q[ch+2] && !syncB_q[ch+2];
            assign trig  = ctrl_q[tgei_pkg::TRIG_A_BIT + ch];
            assign gate  = ctrl_q[tgei_pkg::GATE_A_BIT + ch];
            assign run   = ctrl_q[tgei_pkg::RUN_A_BIT + ch];
            assign cmode = ctrl_q[tgei_pkg::CMODE_A_BIT + ch];
            assign clr   = wrAcc && avsByteEnable[0]
                           && avsAddress == tgei_pkg::STAT_OFS
                           && avsWriteData[tgei_pkg::PEND_A_BIT + ch];
            // gate pin high permits counting when gating is selected
            assign tick  = run && (!gate || syncB_q[ch])
                           && (cmode ? cntFall : 1'b1);

            // set beats clear so no event is lost
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pend_q[ch] <= 1'b0;
                end else if (clkEn) begin
                    if (trig ? irqFall : irqLow) begin
                        pend_q[ch] <= 1'b1;
                    end else if (clr) begin
                        pend_q[ch] <= 1'b0;
                    end
                end
            end

            // count: software write loads, else ticks advance
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    cnt_q[ch] <= tgei_pkg::CNT_RST;
                end else if (wrAcc && avsByteEnable[1:0] == 2'h3
                             && avsAddress == (ch == 0
                                ? tgei_pkg::CNTA_OFS
                                : tgei_pkg::CNTB_OFS)) begin
                    cnt_q[ch] <= avsWriteData[tgei_pkg::CNT_W-1:0];
                end else if (clkEn && tick) begin
                    cnt_q[ch] <= cnt_q[ch] + 16'h0001;
                end
            end
        end
    endgenerate

    // flags mirrored to a registered output
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irqPending <= 2'h0;
        end else if (clkEn) begin
            irqPending <= pend_q;
        end
    end

endmodule : tgei_timer_gate_irq
